// File: bench/msr_status_properties.sv
// Port-level checker for the status register bank.
// Bound to msr_status_regs from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module msr_status_properties #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire msr_pkg::msr_event_type evt,
  input wire msr_pkg::msr_enable_cmd_type en_cmd,
  input wire logic [WIDTH-1:0] quality_status,
  input wire logic [WIDTH-1:0] progress_status,
  input wire logic [WIDTH-1:0] quality_enable,
  input wire logic [WIDTH-1:0] progress_enable,
  input wire logic [7:0] status_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence done_s;
    clk_en && evt.meas_done;
  endsequence
  sequence cal_end_s;
    clk_en && evt.zero_cal_end;
  endsequence
  chk_power_set: assert property (done_s ##0 evt.power_err |=> quality_status[3])
    else $error("power flag not set");
  chk_cal_result: assert property (cal_end_s |=>
    quality_status[8] == $past(evt.zero_cal_err))
    else $error("calibration flag wrong");
  chk_self_test: assert property (clk_en && evt.selftest_done |=>
    quality_status[9] == $past(evt.selftest_fail))
    else $error("self test flag wrong");
  chk_unused_zero: assert property (
    (quality_status & ~msr_pkg::QUALITY_USED) == '0 &&
    (progress_status & ~msr_pkg::PROGRESS_USED) == '0)
    else $error("unused bit set");
  chk_measuring_set: assert property (clk_en && evt.meas_start |=> progress_status[4])
    else $error("measuring flag not set");
  chk_sense_follow: assert property (clk_en |=>
    progress_status[10] == $past(evt.sensor_reading))
    else $error("sensor flag lags");
  chk_lower_fail: assert property (done_s |=>
    progress_status[11] == $past(evt.lower_enabled && evt.lower_fail))
    else $error("lower limit flag wrong");
  chk_upper_fail: assert property (done_s |=>
    progress_status[12] == $past(evt.upper_enabled && evt.upper_fail))
    else $error("upper limit flag wrong");
  chk_quality_sum: assert property (
    status_byte[3] == |(quality_status & quality_enable))
    else $error("quality summary wrong");
  chk_progress_sum: assert property (
    status_byte[7] == |(progress_status & progress_enable))
    else $error("progress summary wrong");
endmodule : msr_status_properties
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the status register bank.
// Drives events and mask commands directly at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  msr_pkg::msr_event_type evt = '0;
  msr_pkg::msr_enable_cmd_type en_cmd = '0;
  logic [15:0] quality_status, progress_status, quality_enable, progress_enable;
  logic [7:0] status_byte;
  int n_mismatch = 0;
  int n_tests = 0;
  msr_status_regs msr_status_regs_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .evt(evt), .en_cmd(en_cmd), .quality_status(quality_status),
    .progress_status(progress_status), .quality_enable(quality_enable),
    .progress_enable(progress_enable), .status_byte(status_byte));
  initial forever #5 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  // Event bits from the top: start done perr zs ze zerr sd sf wt idle sns le lf ue uf
  task automatic step(input logic [14:0] e, input logic [15:0] q, p, input logic [17:0] c = '0);
    @(negedge clock);
    evt = e;
    en_cmd = c;
    @(negedge clock);
    evt = '0;
    en_cmd = '0;
    check(quality_status, q);
    check(progress_status, p);
    check({8'h00, status_byte},
      {8'h00, |(p & 16'h1000), 3'h0, |(q & 16'h0308), 3'h0});
  endtask : step
  task automatic t_reset;
    check(quality_status | progress_status, msr_pkg::STATUS_RESET);
    step(15'h0, 16'h0, 16'h0, 18'h20308);
    step(15'h0, 16'h0, 16'h0, 18'h11000);
    check(quality_enable, 16'h0308);
    check(progress_enable, 16'h1000);
  endtask : t_reset
  task automatic t_measure;
    step(15'h4000, 16'h0, 16'h0010);
    step(15'h300C, 16'h0008, 16'h0800);
    step(15'h2003, 16'h0, 16'h1000);
    step(15'h2000, 16'h0, 16'h0);
  endtask : t_measure
  task automatic t_cal;
    step(15'h0800, 16'h0, 16'h0001);
    step(15'h0600, 16'h0100, 16'h0);
    step(15'h0400, 16'h0, 16'h0);
    step(15'h0180, 16'h0200, 16'h0);
    step(15'h0100, 16'h0, 16'h0);
  endtask : t_cal
  task automatic t_trigger;
    step(15'h0040, 16'h0, 16'h0020);
    step(15'h0010, 16'h0, 16'h0420);
    step(15'h0020, 16'h0, 16'h0);
  endtask : t_trigger
  task automatic t_freeze;
    clk_en = 1'h0;
    step(15'h0180, 16'h0, 16'h0);
    clk_en = 1'h1;
  endtask : t_freeze
  task automatic t_reset_mid;
    step(15'h0180, 16'h0200, 16'h0);
    rst_n = 1'h0;
    @(negedge clock);
    check(quality_status | progress_status, msr_pkg::STATUS_RESET);
    check(quality_enable | progress_enable, msr_pkg::ENABLE_RESET);
    check({8'h00, status_byte}, 16'h0000);
    rst_n = 1'h1;
    step(15'h0, 16'h0, 16'h0);
  endtask : t_reset_mid
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'h1;
    t_reset();
    t_measure();
    t_cal();
    t_trigger();
    t_freeze();
    t_reset_mid();
    end_of_test();
  end
  initial begin
    #5000;
    n_mismatch++;
    end_of_test();
  end
endmodule : testbench
bind msr_status_regs msr_status_properties #(.WIDTH(WIDTH)) msr_status_properties_inst (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .evt(evt), .en_cmd(en_cmd),
  .quality_status(quality_status), .progress_status(progress_status),
  .quality_enable(quality_enable), .progress_enable(progress_enable),
  .status_byte(status_byte));
`default_nettype wire

// File: src/msr_pkg.sv
// Package for the measurement status register bank.
// Assumes one 100 MHz clock domain shared by all users.
`default_nettype none
package msr_pkg;
  localparam int unsigned REG_WIDTH = 16;
  // Quality group bit positions
  localparam int unsigned QB_POWER = 3;
  localparam int unsigned QB_CAL = 8;
  localparam int unsigned QB_SELFTEST = 9;
  // Progress group bit positions
  localparam int unsigned OB_CALIBRATING = 0;
  localparam int unsigned OB_MEASURING = 4;
  localparam int unsigned OB_WAIT_TRIG = 5;
  localparam int unsigned OB_SENSOR_READ = 10;
  localparam int unsigned OB_LOWER_FAIL = 11;
  localparam int unsigned OB_UPPER_FAIL = 12;
  // Status byte summary positions
  localparam int unsigned SB_QUALITY = 3;
  localparam int unsigned SB_PROGRESS = 7;
  // Masks of implemented bits
  localparam logic [15:0] QUALITY_USED = 16'h0308;
  localparam logic [15:0] PROGRESS_USED = 16'h1C31;
  // Values after reset
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [7:0] SUMMARY_RESET = 8'h00;

  // Events reported by the measurement engine, one-cycle pulses unless noted
  typedef struct packed {
    logic meas_start;
    logic meas_done;
    logic power_err;
    logic zero_cal_start;
    logic zero_cal_end;
    logic zero_cal_err;
    logic selftest_done;
    logic selftest_fail;
    logic enter_wait_trig;
    logic enter_idle;
    logic sensor_reading;
    logic lower_enabled;
    logic lower_fail;
    logic upper_enabled;
    logic upper_fail;
  } msr_event_type;

  // Host command to load an enable mask
  typedef struct packed {
    logic quality_we;
    logic progress_we;
    logic [15:0] data;
  } msr_enable_cmd_type;
endpackage : msr_pkg
`default_nettype wire

// File: src/msr_status_regs.sv
// Quality and progress status condition registers with enable masks.
// Assumes event inputs are synchronous pulses or levels from the engine.
// Summary of operation
// - Enabled quality condition bits drive the quality summary.
// - Quality bit 3 sets on any power data error of a measurement.
// - Quality bit 3 clears after an error-free measurement.
// - Quality bit 8 sets when a zero or calibration operation errors.
// - Quality bit 8 clears when such an operation succeeds cleanly.
// - Quality bit 9 follows power-on self test fail or pass.
// - Progress bit 0 set at zero or calibration start, cleared at end.
// - Progress bit 4 is high while a measurement runs.
// - Progress bit 5 set entering wait for trigger, cleared entering idle.
// - Progress bit 10 is high while sensor memory is read.
// - Progress bit 11 sets when a measurement fails a lower limit.
// - Progress bit 11 clears when lower test disabled or passes.
// - Progress bit 12 sets when a measurement fails an upper limit.
// - Progress bit 12 clears when upper test disabled or passes.
// - Enabled quality summary appears as status byte bit 3.
// - Enabled progress summary appears as status byte bit 7.
`timescale 1ns/1ns
`default_nettype none
module msr_status_regs #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire msr_pkg::msr_event_type evt,
  input wire msr_pkg::msr_enable_cmd_type en_cmd,
  output logic [WIDTH-1:0] quality_status,
  output logic [WIDTH-1:0] progress_status,
  output logic [WIDTH-1:0] quality_enable,
  output logic [WIDTH-1:0] progress_enable,
  output logic [7:0] status_byte
);
  // Package constants brought to the register width
  localparam logic [WIDTH-1:0] QUAL_KEEP = WIDTH'(msr_pkg::QUALITY_USED);
  localparam logic [WIDTH-1:0] PROG_KEEP = WIDTH'(msr_pkg::PROGRESS_USED);
  localparam logic [WIDTH-1:0] STAT_INIT = WIDTH'(msr_pkg::STATUS_RESET);
  localparam logic [WIDTH-1:0] MASK_INIT = WIDTH'(msr_pkg::ENABLE_RESET);

  // Enable masks written by the host
  logic [WIDTH-1:0] qen_q;
  logic [WIDTH-1:0] qen_d;
  logic [WIDTH-1:0] pen_q;
  logic [WIDTH-1:0] pen_d;
  // Condition registers
  logic [WIDTH-1:0] qual_q;
  logic [WIDTH-1:0] qual_d;
  logic [WIDTH-1:0] prog_q;
  logic [WIDTH-1:0] prog_d;
  // Summary byte and the two group summaries feeding it
  logic [7:0] sb_q;
  logic [7:0] sb_d;
  logic qual_sum;
  logic prog_sum;

  // Latch a result on its strobe, otherwise hold
  function automatic logic capture(
    input logic current,
    input logic strobe,
    input logic value
  );
    logic result;
    result = current;
    if (strobe) begin
      result = value;
    end
    return result;
  endfunction : capture

  // Set wins over clear so a run starting as the last one ends is kept
  function automatic logic set_wins(
    input logic current,
    input logic set_evt,
    input logic clear_evt
  );
    logic result;
    result = current;
    if (clear_evt) begin
      result = 1'h0;
    end
    if (set_evt) begin
      result = 1'h1;
    end
    return result;
  endfunction : set_wins

  // A disabled limit test counts as passed
  function automatic logic limit_failed(
    input logic enabled,
    input logic failed
  );
    return enabled & failed;
  endfunction : limit_failed

  // Unimplemented bits never reach a condition register
  function automatic logic [WIDTH-1:0] keep_used(
    input logic [WIDTH-1:0] value,
    input logic [WIDTH-1:0] used
  );
    return value & used;
  endfunction : keep_used

  // Mask loads come only from host commands; bits beyond the used ones are kept but inert
  always_comb begin
    qen_d = qen_q;
    pen_d = pen_q;
    if (en_cmd.quality_we) begin
      qen_d = WIDTH'(en_cmd.data);
    end
    if (en_cmd.progress_we) begin
      pen_d = WIDTH'(en_cmd.data);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qen_q <= MASK_INIT;
      pen_q <= MASK_INIT;
    end else if (clk_en) begin
      qen_q <= qen_d;
      pen_q <= pen_d;
    end
  end

  // Each quality bit is decided afresh by the operation that owns it
  always_comb begin
    qual_d = qual_q;
    qual_d[msr_pkg::QB_POWER] = capture(
      qual_q[msr_pkg::QB_POWER],
      evt.meas_done,
      evt.power_err
    );
    qual_d[msr_pkg::QB_CAL] = capture(
      qual_q[msr_pkg::QB_CAL],
      evt.zero_cal_end,
      evt.zero_cal_err
    );
    qual_d[msr_pkg::QB_SELFTEST] = capture(
      qual_q[msr_pkg::QB_SELFTEST],
      evt.selftest_done,
      evt.selftest_fail
    );
    qual_d = keep_used(qual_d, QUAL_KEEP);
  end

  // Events that arrive while clk_en is low are dropped, not queued
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qual_q <= STAT_INIT;
    end else if (clk_en) begin
      qual_q <= qual_d;
    end
  end

  // Progress bits follow the engine's start and end events
  always_comb begin
    prog_d = prog_q;
    prog_d[msr_pkg::OB_CALIBRATING] = set_wins(
      prog_q[msr_pkg::OB_CALIBRATING],
      evt.zero_cal_start,
      evt.zero_cal_end
    );
    prog_d[msr_pkg::OB_MEASURING] = set_wins(
      prog_q[msr_pkg::OB_MEASURING],
      evt.meas_start,
      evt.meas_done
    );
    prog_d[msr_pkg::OB_WAIT_TRIG] = set_wins(
      prog_q[msr_pkg::OB_WAIT_TRIG],
      evt.enter_wait_trig,
      evt.enter_idle
    );
    prog_d[msr_pkg::OB_SENSOR_READ] = evt.sensor_reading;
    prog_d[msr_pkg::OB_LOWER_FAIL] = capture(
      prog_q[msr_pkg::OB_LOWER_FAIL],
      evt.meas_done,
      limit_failed(evt.lower_enabled, evt.lower_fail)
    );
    prog_d[msr_pkg::OB_UPPER_FAIL] = capture(
      prog_q[msr_pkg::OB_UPPER_FAIL],
      evt.meas_done,
      limit_failed(evt.upper_enabled, evt.upper_fail)
    );
    prog_d = keep_used(prog_d, PROG_KEEP);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_q <= STAT_INIT;
    end else if (clk_en) begin
      prog_q <= prog_d;
    end
  end

  // Summaries from next-state values so the byte never lags its registers
  msr_summary #(
    .WIDTH(WIDTH)
  ) u_qual_sum (
    .cond(qual_d),
    .mask(qen_d),
    .summary(qual_sum)
  );
  msr_summary #(
    .WIDTH(WIDTH)
  ) u_prog_sum (
    .cond(prog_d),
    .mask(pen_d),
    .summary(prog_sum)
  );

  always_comb begin
    sb_d = msr_pkg::SUMMARY_RESET;
    sb_d[msr_pkg::SB_QUALITY] = qual_sum;
    sb_d[msr_pkg::SB_PROGRESS] = prog_sum;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sb_q <= msr_pkg::SUMMARY_RESET;
    end else if (clk_en) begin
      sb_q <= sb_d;
    end
  end

  // Outputs are the registers themselves
  always_comb begin
    quality_status = qual_q;
    progress_status = prog_q;
    quality_enable = qen_q;
    progress_enable = pen_q;
    status_byte = sb_q;
  end
endmodule : msr_status_regs
`default_nettype wire

// File: src/msr_summary.sv
// Masked summary of one status group.
// Assumes condition and mask come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module msr_summary #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] mask,
  output logic summary
);
  always_comb begin
    summary = |(cond & mask);
  end
endmodule : msr_summary
`default_nettype wire
